// ===== rtl/supervisor_pkg.sv
package supervisor_pkg;

    // Timebase and documented timeouts
    localparam int unsigned CLK_HZ              = 20_000_000;
    localparam int unsigned RESET_HOLD_TIME_US  = 1100;
    localparam int unsigned WDT_LONG_TIME_MS    = 35000;
    localparam int unsigned WDT_NORMAL_TIME_MS  = 1120;
    localparam int unsigned RESET_HOLD_CYCLES   = (RESET_HOLD_TIME_US * (CLK_HZ / 1_000_000));
    localparam longint unsigned WDT_LONG_CYCLES   = longint'(WDT_LONG_TIME_MS) * longint'(CLK_HZ / 1000);
    localparam longint unsigned WDT_NORMAL_CYCLES = longint'(WDT_NORMAL_TIME_MS) * longint'(CLK_HZ / 1000);

    // Reset output drive styles
    localparam bit DRIVE_OPEN_DRAIN = 1'b1;
    localparam bit DRIVE_PUSH_PULL  = 1'b0;

    // Monitor status bundle, each bit high while that cause is active
    typedef struct packed {
        logic primary_supply_low;
        logic secondary_supply_low;
        logic aux_undervolt_in;
    } monitor_t;

    // One reset pin as output value plus output enable
    typedef struct packed {
        logic out;
        logic oe;
    } pin_t;

    // Watchdog mode
    typedef enum logic [1:0] {
        WDT_INITIAL = 2'b00,
        WDT_NORMAL  = 2'b01
    } wdt_mode_t;

endpackage

// ===== rtl/supervisor_reset_watchdog.sv
`timescale 1ns/1ps
module supervisor_reset_watchdog #(
    parameter int unsigned     HOLD_CYCLES   = supervisor_pkg::RESET_HOLD_CYCLES,
    parameter longint unsigned LONG_CYCLES   = supervisor_pkg::WDT_LONG_CYCLES,
    parameter longint unsigned NORMAL_CYCLES = supervisor_pkg::WDT_NORMAL_CYCLES,
    parameter bit              DRIVE_STYLE   = supervisor_pkg::DRIVE_OPEN_DRAIN,
    parameter bit              WDT_FITTED    = 1'b1
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_srst,
    input  wire supervisor_pkg::monitor_t i_monitor,
    input  wire logic                     i_manual_reset_n,
    input  wire logic                     i_watchdog_kick,
    input  wire logic                     i_watchdog_float,
    input  wire logic                     i_powerfail_sense_low,
    output supervisor_pkg::pin_t          o_reset_out_a_n,
    output supervisor_pkg::pin_t          o_reset_out_b_n,
    output supervisor_pkg::pin_t          o_reset_out,
    output supervisor_pkg::pin_t          o_powerfail_alert_n,
    output logic                          o_watchdog_normal
);
    import supervisor_pkg::*;

    localparam int HW = (HOLD_CYCLES > 1) ? $clog2(HOLD_CYCLES + 1) : 1;
    localparam int WW = $clog2(LONG_CYCLES + 1);
    localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);
    localparam logic [WW-1:0] LONG_LAST = WW'(LONG_CYCLES - 1);
    localparam logic [WW-1:0] NORM_LAST = WW'(NORMAL_CYCLES - 1);
    // Drive style decoded once; open-drain pins only ever pull low
    localparam bit            PP_DRIVE  = (DRIVE_STYLE == DRIVE_PUSH_PULL);

    logic [1:0]    sync_mon [3];
    logic [1:0]    sync_mr;
    logic [1:0]    sync_wdi;
    logic [1:0]    sync_flt;
    logic [1:0]    sync_pf;
    logic          wdi_last;
    logic          kick_edge;
    logic          mon_low;
    logic          cause;
    logic          wdt_expire;
    logic          reset_active;
    logic [HW-1:0] hold_cnt;
    logic [WW-1:0] wdt_cnt;
    wdt_mode_t     wdt_mode;
    logic          wdt_on;
    pin_t          rst_low_pin [2];

    // Two-stage synchronisers; logic reads only the second stage
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_mon_sync
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    sync_mon[g] <= 2'h0;
                end else begin
                    sync_mon[g] <= {sync_mon[g][0], i_monitor[g]};
                end
            end
        end
    endgenerate

    // Manual input idles high, so it adds no cause out of reset
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sync_mr <= 2'h3;
        end else begin
            sync_mr <= {sync_mr[0], i_manual_reset_n};
        end
    end

    // Kick input starts low, matching the edge detector's reset level
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sync_wdi <= 2'h0;
        end else begin
            sync_wdi <= {sync_wdi[0], i_watchdog_kick};
        end
    end

    // Float flag starts set, so the watchdog stays off until the pin is seen
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sync_flt <= 2'h3;
        end else begin
            sync_flt <= {sync_flt[0], i_watchdog_float};
        end
    end

    // Comparator starts good, so no alert pulse comes out of reset
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sync_pf <= 2'h0;
        end else begin
            sync_pf <= {sync_pf[0], i_powerfail_sense_low};
        end
    end

    // Either edge on the kick input counts as service
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wdi_last <= 1'b0;
        end else begin
            wdi_last <= sync_wdi[1];
        end
    end
    assign kick_edge = (sync_wdi[1] != wdi_last);

    // Causes; a bouncing manual input keeps re-arming the hold
    assign mon_low = sync_mon[0][1] | sync_mon[1][1] | sync_mon[2][1];
    assign cause   = mon_low | ~sync_mr[1] | wdt_expire;
    assign wdt_on  = WDT_FITTED & ~sync_flt[1];

    // Hold counter restarts from zero whenever any cause is present
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            reset_active <= 1'b1;
            hold_cnt     <= '0;
        end else if (cause) begin
            reset_active <= 1'b1;
            hold_cnt     <= '0;
        end else if (reset_active) begin
            if (hold_cnt == HOLD_LAST) begin
                reset_active <= 1'b0;
            end else begin
                hold_cnt <= hold_cnt + 1'b1;
            end
        end
    end

    // Watchdog: cleared in reset and on every edge, expiry one cycle pulse
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wdt_cnt    <= '0;
            wdt_mode   <= WDT_INITIAL;
            wdt_expire <= 1'b0;
        end else if (reset_active || !wdt_on) begin
            wdt_cnt    <= '0;
            wdt_mode   <= WDT_INITIAL;
            wdt_expire <= 1'b0;
        end else if (kick_edge) begin
            wdt_cnt    <= '0;
            wdt_mode   <= WDT_NORMAL;
            wdt_expire <= 1'b0;
        end else begin
            unique case (wdt_mode)
                WDT_INITIAL: wdt_expire <= (wdt_cnt == LONG_LAST);
                WDT_NORMAL:  wdt_expire <= (wdt_cnt == NORM_LAST);
                default:     wdt_expire <= 1'b0;
            endcase
            wdt_cnt <= wdt_cnt + 1'b1;
        end
    end

    // Both active-low reset pins copy the one reset state, so they cannot disagree
    generate
        for (g = 0; g < 2; g++) begin : g_low_pin
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    rst_low_pin[g] <= '{out: 1'b0, oe: 1'b1};
                end else begin
                    rst_low_pin[g].out <= ~reset_active;
                    rst_low_pin[g].oe  <= PP_DRIVE | reset_active;
                end
            end
        end
    endgenerate
    assign o_reset_out_a_n = rst_low_pin[0];
    assign o_reset_out_b_n = rst_low_pin[1];

    // Active-high pin; open-drain must float it while reset is on
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_reset_out <= '{out: 1'b1, oe: PP_DRIVE};
        end else begin
            o_reset_out.out <= reset_active;
            o_reset_out.oe  <= PP_DRIVE | ~reset_active;
        end
    end

    // Alert follows the comparator directly; no hold timer is applied
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_powerfail_alert_n <= '{out: 1'b1, oe: PP_DRIVE};
        end else begin
            o_powerfail_alert_n.out <= ~sync_pf[1];
            o_powerfail_alert_n.oe  <= PP_DRIVE | sync_pf[1];
        end
    end

    // Mode flag for the processor side, one cycle behind the mode register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_watchdog_normal <= 1'b0;
        end else begin
            o_watchdog_normal <= (wdt_mode == WDT_NORMAL);
        end
    end

endmodule // supervisor_reset_watchdog

// ===== testbench/cpu_kick_model.sv
`timescale 1ns/1ps
// Processor side: toggles the kick every 10 cycles while running
module cpu_kick_model (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_enable,
    input  wire logic i_float,
    output logic      o_kick
);
    int cnt = 0;
    initial o_kick = 1'b0;
    // A floating line sits at one level, so it never services the watchdog
    always @(posedge i_clk) begin
        cnt <= (!i_reset_n || cnt == 9) ? 0 : cnt + 1;
        if (!i_float && i_enable && i_reset_n && cnt == 9)
            o_kick <= !o_kick;
    end
endmodule // cpu_kick_model

// ===== testbench/supervisor_reset_watchdog_asserts.sv
`timescale 1ns/1ps
// Pin-level checks; AST_HOLD_CLEAR takes the hold from the bound instance, AST_HOLD_MIN a fixed 8 cycles
module supervisor_reset_watchdog_asserts #(
    parameter int unsigned HOLD_CYCLES = 8,
    parameter bit          DRIVE_STYLE = 1'b1
) (
    input wire logic                     i_clk,
    input wire logic                     i_srst,
    input wire supervisor_pkg::monitor_t i_monitor,
    input wire logic                     i_manual_reset_n,
    input wire logic                     i_powerfail_sense_low,
    input wire supervisor_pkg::pin_t     o_reset_out_a_n,
    input wire supervisor_pkg::pin_t     o_reset_out_b_n,
    input wire supervisor_pkg::pin_t     o_reset_out,
    input wire supervisor_pkg::pin_t     o_powerfail_alert_n,
    input wire logic                     o_watchdog_normal
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    AST_CAUSE: assert property (i_monitor != 3'h0 |-> ##[1:4] !o_reset_out_a_n.out)
        else $error("supply cause left reset released");
    AST_MANUAL: assert property (!i_manual_reset_n |-> ##[1:4] !o_reset_out_a_n.out)
        else $error("manual low left reset released");
    AST_SAME: assert property (o_reset_out_a_n == o_reset_out_b_n && o_reset_out.out == !o_reset_out_a_n.out)
        else $error("reset outputs disagree");
    AST_DRIVE: assert property (DRIVE_STYLE ? (o_reset_out_a_n.oe == !o_reset_out_a_n.out &&
            o_reset_out.oe == !o_reset_out.out && o_powerfail_alert_n.oe == !o_powerfail_alert_n.out) :
            (o_reset_out_a_n.oe && o_reset_out.oe && o_powerfail_alert_n.oe))
        else $error("output drive enable wrong");
    AST_HOLD_MIN: assert property ($fell(o_reset_out_a_n.out) |=> !o_reset_out_a_n.out [*7])
        else $error("reset pulse too short");
    AST_HOLD_CLEAR: assert property ($rose(o_reset_out_a_n.out) |-> $past(i_monitor == 3'h0 && i_manual_reset_n, HOLD_CYCLES))
        else $error("reset released inside hold");
    AST_PF_LOW: assert property (i_powerfail_sense_low [*5] |-> !o_powerfail_alert_n.out)
        else $error("alert not driven low");
    AST_PF_REL: assert property (!i_powerfail_sense_low [*5] |-> o_powerfail_alert_n.out)
        else $error("alert stretched");
    AST_WDT_INIT: assert property (!o_reset_out_a_n.out [*3] |-> !o_watchdog_normal)
        else $error("watchdog normal during reset");
endmodule // supervisor_reset_watchdog_asserts
bind supervisor_reset_watchdog supervisor_reset_watchdog_asserts
    #(.HOLD_CYCLES(HOLD_CYCLES), .DRIVE_STYLE(DRIVE_STYLE)) u_asserts (.i_clk,
    .i_srst, .i_monitor, .i_manual_reset_n, .i_powerfail_sense_low, .o_reset_out_a_n, .o_reset_out_b_n,
    .o_reset_out, .o_powerfail_alert_n, .o_watchdog_normal);

// ===== testbench/test_supervisor_reset_watchdog.sv
`timescale 1ns/1ps
// Causes with bounces, watchdog modes, floating kick, power-fail alert
module test_supervisor_reset_watchdog;
    import supervisor_pkg::*;
    localparam int HOLD = 8, LONG = 50, NORM = 20;
    logic i_clk = 1'b0, i_srst = 1'b1, mr_n = 1'b1, flt = 1'b0, pf = 1'b0, run = 1'b0, kick, v, wn;
    monitor_t mon = 3'h0;
    pin_t rst_a, rst_b, rst_h, alert, rst_pp, alert_pp;
    wire rst_a_pin = rst_a.oe ? rst_a.out : 1'b1; // Pull-up holds a released pin high
    int miscompares = 0, total_checks = 0, seed = 20067, cycles = 0, n, k;
    logic q[$];
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
    always #25 i_clk = ~i_clk;
    supervisor_reset_watchdog #(.HOLD_CYCLES(HOLD), .LONG_CYCLES(LONG), .NORMAL_CYCLES(NORM)) i_dut (.i_clk,
        .i_srst, .i_monitor(mon), .i_manual_reset_n(mr_n), .i_watchdog_kick(kick), .i_watchdog_float(flt),
        .i_powerfail_sense_low(pf), .o_reset_out_a_n(rst_a), .o_reset_out_b_n(rst_b), .o_reset_out(rst_h),
        .o_powerfail_alert_n(alert), .o_watchdog_normal(wn));
    // Push-pull build on the same inputs
    supervisor_reset_watchdog #(.HOLD_CYCLES(HOLD), .LONG_CYCLES(LONG), .NORMAL_CYCLES(NORM),
        .DRIVE_STYLE(DRIVE_PUSH_PULL)) i_dut_pp (.i_clk, .i_srst, .i_monitor(mon), .i_manual_reset_n(mr_n),
        .i_watchdog_kick(kick), .i_watchdog_float(flt), .i_powerfail_sense_low(pf), .o_reset_out_a_n(rst_pp),
        .o_reset_out_b_n(), .o_reset_out(), .o_powerfail_alert_n(alert_pp), .o_watchdog_normal());
    cpu_kick_model i_cpu (.i_clk, .i_reset_n(rst_a_pin), .i_enable(run), .i_float(flt), .o_kick(kick));
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Bounded wait on negedges, so outputs have settled
    task wait_rst(input logic lvl, output int c);
        c = 0;
        while (rst_a.out !== lvl && c < 400) begin
            @(negedge i_clk);
            c++;
        end
        if (rst_a.out !== lvl) begin
            miscompares++;
            $display("unexpected reset level expected %0h seen %0h", lvl, rst_a.out);
        end
    endtask
    // Hang guard far above the expected run
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            summarize;
        end
    end
    initial begin
        repeat (16) @(posedge i_clk);
        i_srst <= 1'b0;
        wait_rst(1'b1, n);
        // Bounces 5 clear cycles apart: without a restart release comes too early
        for (int i = 0; i < 4; i++) begin
            repeat (1 + $unsigned($random(seed)) % 3) begin
                @(posedge i_clk);
                mon <= (i < 3) ? monitor_t'(3'h1 << i) : 3'h0;
                mr_n <= (i != 3);
                repeat (1 + $unsigned($random(seed)) % 3) @(posedge i_clk);
                mon <= 3'h0;
                mr_n <= 1'b1;
                repeat (4) @(posedge i_clk);
            end
            @(negedge i_clk);
            `CHK("reset on", 1'b0, rst_a.out)
            `CHK("reset b", 1'b0, rst_b.out)
            `CHK("reset a drive", 2'h1, {rst_a.out, rst_a.oe})
            `CHK("reset high", 2'h2, {rst_h.out, rst_h.oe})
            `CHK("pp reset", 2'h1, {rst_pp.out, rst_pp.oe})
            wait_rst(1'b1, n);
            `CHK("hold", 1'b1, n + 4 >= HOLD + 2 && n + 4 <= HOLD + 5)
            `CHK("released drive", 4'h9, {rst_b.out, rst_a.oe, rst_h.out, rst_h.oe})
            `CHK("pp released", 2'h3, {rst_pp.out, rst_pp.oe})
        end
        $display("test causes done");
        wait_rst(1'b0, n);
        `CHK("long expiry", 1'b1, n >= LONG - 2 && n <= LONG + 6)
        wait_rst(1'b1, n);
        @(posedge i_clk) run <= 1'b1;
        repeat (100) @(negedge i_clk);
        `CHK("kicked", 2'h3, {rst_a.out, wn})
        @(posedge i_clk) run <= 1'b0;
        wait_rst(1'b0, n);
        `CHK("normal expiry", 1'b1, n >= NORM - 10 && n <= NORM + 6)
        wait_rst(1'b1, n);
        `CHK("initial mode", 1'b0, wn)
        $display("test watchdog done");
        @(posedge i_clk) flt <= 1'b1;
        k = 0;
        repeat (3 * LONG) begin
            @(negedge i_clk);
            k += (rst_a.out !== 1'b1);
        end
        `CHK("float reset", 0, k)
        repeat (12) begin
            v = $random(seed);
            q.push_back(!v);
            @(posedge i_clk) pf <= v;
            repeat (6) @(negedge i_clk);
            k = q.pop_front();
            `CHK("alert", k[0], alert.out)
            `CHK("alert drive", {!k[0], k[0], 1'b1}, {alert.oe, alert_pp.out, alert_pp.oe})
        end
        $display("test float and alert done");
        summarize;
    end
endmodule // test_supervisor_reset_watchdog
